// [core/pmr_defs.svh]
// constants of the power-management event router: offsets, fields, resets, times
// assumes 32-bit APB data, one register per aligned word, byte address = index * 4
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// register indices; byte address is the index shifted left by two
`define PMR_IDX_DEV_STS      10'h0f3
`define PMR_IDX_AUX_STS      10'h0f4
`define PMR_IDX_DEV_EN       10'h0f6
`define PMR_IDX_AUX_EN       10'h0f7
`define PMR_IDX_OUT_CTL      10'h0f9
`define PMR_IDX_TEST_LO      10'h0fe
`define PMR_IDX_TEST_HI      10'h0ff
`define PMR_IDX_EVT_STS      10'h0e8
`define PMR_IDX_EVT_MASK     10'h0e9

// implemented bits per register; all other bits read zero
`define PMR_DEV_MASK         8'h7f
`define PMR_AUX_MASK         8'h17
`define PMR_CTL_MASK         8'h07
`define PMR_EVT_MASK         8'h03
`define PMR_REG_RESET        8'h00

// device status and enable bit positions
`define PMR_DEV_SERIAL_C     6
`define PMR_DEV_POINTER      5
`define PMR_DEV_KEYBOARD     4
`define PMR_DEV_PRINTER      3
`define PMR_DEV_FLOPPY       2
`define PMR_DEV_SERIAL_A     1
`define PMR_DEV_SERIAL_B     0

// auxiliary status and enable bit positions
`define PMR_AUX_WATCHDOG     4
`define PMR_AUX_PIN_GROUP    2
`define PMR_AUX_PIN11        1
`define PMR_AUX_PIN10        0

// output control fields
`define PMR_CTL_OE_BIT       0
`define PMR_CTL_FAST_BIT     1
`define PMR_CTL_ROUTE_BIT    2

// block event status fields
`define PMR_EVT_REQ_BIT      0
`define PMR_EVT_TICK_BIT     1

// idle-expiry times
`define PMR_CLK_HZ           100000000
`define PMR_SLOW_EXPIRY_S    1
`define PMR_FAST_EXPIRY_MS   8
`define PMR_SLOW_EXPIRY_CYC  (`PMR_SLOW_EXPIRY_S * `PMR_CLK_HZ)
`define PMR_FAST_EXPIRY_CYC  (`PMR_FAST_EXPIRY_MS * (`PMR_CLK_HZ / 1000))
`define PMR_CNT_W            27

`endif

// [core/pmr_pkg.sv]
// types of the power-management event router
// assumes pmr_defs.svh is on the include path
`include "pmr_defs.svh"

package pmr_pkg;

  typedef logic [`PMR_CNT_W-1:0] pmr_cnt_t;

  typedef struct packed {
    logic [7:0]  dev_sts;
    logic [7:0]  aux_sts;
    logic [7:0]  dev_en;
    logic [7:0]  aux_en;
    logic [7:0]  ctl;
    logic [7:0]  evt_sts;
    logic [7:0]  evt_mask;
    logic [31:0] rdata;
    logic        slverr;
    logic        req;
    pmr_cnt_t    cnt;
    logic        tick;
    logic        smi_n;
    logic        sci_n;
    logic        smi_oe;
    logic        sci_oe;
  } pmr_state_s;

endpackage

// [core/pmr_router.sv]
// power-management event router: latches, enables, smi/sci routing, idle expiry
// assumes synchronous source levels, an APB master on i_mclk, open-drain pins outside
//
// Summary of operation
// - each device status bit sets from its source; write one clears, zero keeps
// - device bits: 6 serial c, 5 pointer, 4 keyboard, 3 printer, 2 floppy, 1 a, 0 b
// - aux bits: 4 watchdog, 2 pin group, 1 pin 11, 0 pin 10; write-one clear
// - request is OR over all sources of status AND enable
// - device enable register mirrors device status bit order, bits 6 to 0
// - aux enables at bits 4, 2, 1, 0 match aux status positions
// - output enable zero drives neither pin; one asserts selected pin on request
// - route select zero sends to smi, one to sci, only when output enabled
// - fast select picks 8 ms idle expiry, else 1 second
// - reserved bits of status, enable and control registers read zero
// - all registers reset to zero; factory test indices read zero
//
// The APB slave port was decided locally.
`include "pmr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module pmr_router #(
  parameter int unsigned P_SLOW_CYC = `PMR_SLOW_EXPIRY_CYC,
  parameter int unsigned P_FAST_CYC = `PMR_FAST_EXPIRY_CYC
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // device interrupt sources
  input  wire logic        i_serial_c_irq,
  input  wire logic        i_pointer_irq,
  input  wire logic        i_keyboard_ctl_irq,
  input  wire logic        i_printer_irq,
  input  wire logic        i_floppy_irq,
  input  wire logic        i_serial_a_irq,
  input  wire logic        i_serial_b_irq,
  // auxiliary interrupt sources
  input  wire logic        i_watchdog_irq,
  input  wire logic        i_pin_group_20_25_irq,
  input  wire logic        i_pin11_steer_irq,
  input  wire logic        i_pin10_steer_irq,
  // power-management pins, open drain
  output logic             o_smi_n,
  output logic             o_smi_oe,
  output logic             o_sci_n,
  output logic             o_sci_oe,
  // idle expiry
  output logic             o_fast_expiry_select,
  output logic             o_expiry_tick,
  // block interrupt
  output logic             o_irq
);
  import pmr_pkg::*;

  pmr_state_s s_q;
  pmr_state_s s_d;

  logic [7:0] dev_src;
  logic [7:0] aux_src;
  logic [9:0] idx;
  logic       aligned;
  logic       setup;
  logic       access;
  logic       wr_acc;
  logic       rd_acc;
  logic       hit;
  logic [7:0] rd_val;
  logic [7:0] wbyte;
  logic       req_comb;
  pmr_cnt_t   limit;
  logic       wrap;

  // source bit placement
  always_comb begin
    dev_src = 8'h00;
    aux_src = 8'h00;
    dev_src[`PMR_DEV_SERIAL_C] = i_serial_c_irq;
    dev_src[`PMR_DEV_POINTER]  = i_pointer_irq;
    dev_src[`PMR_DEV_KEYBOARD] = i_keyboard_ctl_irq;
    dev_src[`PMR_DEV_PRINTER]  = i_printer_irq;
    dev_src[`PMR_DEV_FLOPPY]   = i_floppy_irq;
    dev_src[`PMR_DEV_SERIAL_A] = i_serial_a_irq;
    dev_src[`PMR_DEV_SERIAL_B] = i_serial_b_irq;
    aux_src[`PMR_AUX_WATCHDOG]  = i_watchdog_irq;
    aux_src[`PMR_AUX_PIN_GROUP] = i_pin_group_20_25_irq;
    aux_src[`PMR_AUX_PIN11]     = i_pin11_steer_irq;
    aux_src[`PMR_AUX_PIN10]     = i_pin10_steer_irq;
  end

  // apb phases
  assign idx     = i_paddr[11:2];
  assign aligned = (i_paddr[1:0] == 2'b00);
  assign setup   = i_psel & ~i_penable;
  assign access  = i_psel & i_penable;
  assign wr_acc  = access & i_pwrite & i_pstrb[0] & hit;
  assign rd_acc  = access & ~i_pwrite & hit;
  assign wbyte   = i_pwdata[7:0];
  assign o_pready = access;

  // address decode and read value
  always_comb begin
    hit    = 1'b1;
    rd_val = 8'h00;
    if (!aligned) begin
      hit = 1'b0;
    end else if (idx == `PMR_IDX_DEV_STS) begin
      rd_val = s_q.dev_sts & `PMR_DEV_MASK;
    end else if (idx == `PMR_IDX_AUX_STS) begin
      rd_val = s_q.aux_sts & `PMR_AUX_MASK;
    end else if (idx == `PMR_IDX_DEV_EN) begin
      rd_val = s_q.dev_en & `PMR_DEV_MASK;
    end else if (idx == `PMR_IDX_AUX_EN) begin
      rd_val = s_q.aux_en & `PMR_AUX_MASK;
    end else if (idx == `PMR_IDX_OUT_CTL) begin
      rd_val = s_q.ctl & `PMR_CTL_MASK;
    end else if (idx == `PMR_IDX_TEST_LO || idx == `PMR_IDX_TEST_HI) begin
      rd_val = `PMR_REG_RESET;
    end else if (idx == `PMR_IDX_EVT_STS) begin
      rd_val = s_q.evt_sts & `PMR_EVT_MASK;
    end else if (idx == `PMR_IDX_EVT_MASK) begin
      rd_val = s_q.evt_mask & `PMR_EVT_MASK;
    end else begin
      hit = 1'b0;
    end
  end

  // combined request; pin 11 term kept through the aux mask
  assign req_comb = |(s_q.dev_sts & s_q.dev_en)
                  | |(s_q.aux_sts & s_q.aux_en & `PMR_AUX_MASK);

  // expiry period follows the fast select
  assign limit = s_q.ctl[`PMR_CTL_FAST_BIT] ? pmr_cnt_t'(P_FAST_CYC - 1)
                                            : pmr_cnt_t'(P_SLOW_CYC - 1);
  assign wrap  = (s_q.cnt >= limit);

  always_comb begin
    s_d = s_q;
    // status latches: a source event wins over a clear in the same cycle
    s_d.dev_sts = (s_q.dev_sts & ~((wr_acc && idx == `PMR_IDX_DEV_STS) ? wbyte : 8'h00)
                  | dev_src) & `PMR_DEV_MASK;
    s_d.aux_sts = (s_q.aux_sts & ~((wr_acc && idx == `PMR_IDX_AUX_STS) ? wbyte : 8'h00)
                  | aux_src) & `PMR_AUX_MASK;
    if (wr_acc && idx == `PMR_IDX_DEV_EN) begin
      s_d.dev_en = wbyte & `PMR_DEV_MASK;
    end
    if (wr_acc && idx == `PMR_IDX_AUX_EN) begin
      s_d.aux_en = wbyte & `PMR_AUX_MASK;
    end
    if (wr_acc && idx == `PMR_IDX_OUT_CTL) begin
      s_d.ctl = wbyte & `PMR_CTL_MASK;
    end
    if (wr_acc && idx == `PMR_IDX_EVT_MASK) begin
      s_d.evt_mask = wbyte & `PMR_EVT_MASK;
    end
    // block events: read clears, a new event in the same cycle survives
    if (rd_acc && idx == `PMR_IDX_EVT_STS) begin
      s_d.evt_sts = 8'h00;
    end
    if (req_comb && !s_q.req) begin
      s_d.evt_sts[`PMR_EVT_REQ_BIT] = 1'b1;
    end
    if (s_q.tick) begin
      s_d.evt_sts[`PMR_EVT_TICK_BIT] = 1'b1;
    end
    // read data captured in the setup cycle
    if (setup) begin
      s_d.rdata  = {24'h000000, rd_val};
      s_d.slverr = ~hit;
    end
    // idle expiry divider
    s_d.cnt  = wrap ? '0 : s_q.cnt + pmr_cnt_t'(1);
    s_d.tick = wrap;
    // pin routing
    s_d.req    = req_comb;
    s_d.smi_oe = s_q.ctl[`PMR_CTL_OE_BIT] & ~s_q.ctl[`PMR_CTL_ROUTE_BIT];
    s_d.sci_oe = s_q.ctl[`PMR_CTL_OE_BIT] &  s_q.ctl[`PMR_CTL_ROUTE_BIT];
    s_d.smi_n  = ~(s_d.smi_oe & req_comb);
    s_d.sci_n  = ~(s_d.sci_oe & req_comb);
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{smi_n: 1'b1, sci_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata             = s_q.rdata;
  assign o_pslverr            = access & s_q.slverr;
  assign o_smi_n              = s_q.smi_n;
  assign o_smi_oe             = s_q.smi_oe;
  assign o_sci_n              = s_q.sci_n;
  assign o_sci_oe             = s_q.sci_oe;
  assign o_fast_expiry_select = s_q.ctl[`PMR_CTL_FAST_BIT];
  assign o_expiry_tick        = s_q.tick;
  assign o_irq                = |(s_q.evt_sts & s_q.evt_mask);

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  logic [`PMR_CNT_W-1:0] gap_q;
  logic                  gap_ok_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      gap_q    <= '0;
      gap_ok_q <= 1'b0;
    end else if (s_q.tick) begin
      gap_q    <= '0;
      gap_ok_q <= 1'b1;
    end else begin
      gap_q    <= gap_q + pmr_cnt_t'(1);
      if (s_q.ctl[`PMR_CTL_FAST_BIT] != s_d.ctl[`PMR_CTL_FAST_BIT]) begin
        gap_ok_q <= 1'b0;
      end
    end
  end

  a_dev_set_latch: assert property (
    (dev_src != 8'h00) |=> ((s_q.dev_sts & $past(dev_src)) == $past(dev_src)))
    else $error("device status missed its source");

  a_dev_zero_keep: assert property (
    (wr_acc && idx == `PMR_IDX_DEV_STS && wbyte == 8'h00 && dev_src == 8'h00)
    |=> (s_q.dev_sts == $past(s_q.dev_sts)))
    else $error("writing zero changed device status");

  a_floppy_bit_map: assert property (
    i_floppy_irq ##1 !i_psel |-> s_q.dev_sts[2] ##2 (o_prdata[2] || !i_psel || !i_penable
      || idx != `PMR_IDX_DEV_STS))
    else $error("floppy source not at bit 2");

  a_aux_clear_one: assert property (
    (wr_acc && idx == `PMR_IDX_AUX_STS && wbyte[4] && !i_watchdog_irq)
    |=> !s_q.aux_sts[4])
    else $error("watchdog status not cleared by one");

  a_smi_on_request: assert property (
    (s_q.ctl[2:0] == 3'b001 && (s_q.dev_sts & s_q.dev_en) != 8'h00 && !i_psel)
    |=> (!o_smi_n && o_smi_oe && o_sci_oe == 1'b0))
    else $error("smi not asserted for pending device event");

  a_pin11_to_sci: assert property (
    (s_q.ctl[2:0] == 3'b101 && s_q.aux_sts[1] && s_q.aux_en[1] && !i_psel)
    |=> (!o_sci_n && o_smi_n))
    else $error("pin 11 steering term not routed to sci");

  a_oe_off_quiet: assert property (
    (!s_q.ctl[`PMR_CTL_OE_BIT] && !i_psel) |=> (!o_smi_oe && !o_sci_oe && o_smi_n && o_sci_n))
    else $error("pin driven while output enable is zero");

  a_route_exclusive: assert property (
    !(o_smi_oe && o_sci_oe) && (o_smi_n || o_smi_oe) && (o_sci_n || o_sci_oe))
    else $error("both pins driven or undriven pin asserted");

  a_fast_expiry_gap: assert property (
    (s_q.tick && gap_ok_q && s_q.ctl[`PMR_CTL_FAST_BIT])
    |-> (gap_q == pmr_cnt_t'(P_FAST_CYC - 1)))
    else $error("fast expiry period wrong");

  a_reserved_zero: assert property (
    (setup && hit) |=> (o_prdata[31:8] == 24'h000000 && !(idx == `PMR_IDX_DEV_STS
      && o_prdata[7]) && !(idx == `PMR_IDX_OUT_CTL && o_prdata[7:3] != 5'h00)))
    else $error("reserved bits read non-zero");

  a_reset_values: assert property (
    $past(i_rst) |-> (s_q.dev_en == 8'h00 && s_q.aux_en == 8'h00 && s_q.ctl == 8'h00
      && o_smi_n && o_sci_n))
    else $error("register not zero after reset");

  a_aux_set_latch: assert property (
    (aux_src != 8'h00) |=> ((s_q.aux_sts & $past(aux_src)) == $past(aux_src)))
    else $error("aux status missed its source");

  a_aux_zero_keep: assert property (
    (wr_acc && idx == `PMR_IDX_AUX_STS && wbyte == 8'h00 && aux_src == 8'h00)
    |=> (s_q.aux_sts == $past(s_q.aux_sts)))
    else $error("writing zero changed aux status");

  a_dev_clear_one: assert property (
    (wr_acc && idx == `PMR_IDX_DEV_STS && dev_src == 8'h00)
    |=> ((s_q.dev_sts & $past(wbyte)) == 8'h00))
    else $error("device status not cleared by one");

  a_watchdog_term: assert property (
    (s_q.aux_sts[`PMR_AUX_WATCHDOG] && s_q.aux_en[`PMR_AUX_WATCHDOG]) |=> s_q.req)
    else $error("watchdog term missing from request");

  a_req_any_term: assert property (
    (((s_q.dev_sts & s_q.dev_en) != 8'h00) || ((s_q.aux_sts & s_q.aux_en) != 8'h00))
    |=> s_q.req)
    else $error("request low with an enabled status set");

  a_req_idle_low: assert property (
    (((s_q.dev_sts & s_q.dev_en) == 8'h00) && ((s_q.aux_sts & s_q.aux_en) == 8'h00))
    |=> !s_q.req)
    else $error("request high with no enabled status");

  a_dev_en_write: assert property (
    (wr_acc && idx == `PMR_IDX_DEV_EN) |=> (s_q.dev_en == ($past(wbyte) & `PMR_DEV_MASK)))
    else $error("device enable write lost");

  a_aux_en_write: assert property (
    (wr_acc && idx == `PMR_IDX_AUX_EN) |=> (s_q.aux_en == ($past(wbyte) & `PMR_AUX_MASK)))
    else $error("aux enable write lost");

  a_sci_on_request: assert property (
    (s_q.ctl[2:0] == 3'b101 && (s_q.dev_sts & s_q.dev_en) != 8'h00 && !i_psel)
    |=> (!o_sci_n && o_sci_oe && !o_smi_oe))
    else $error("sci not asserted for pending device event");

  a_slow_expiry_gap: assert property (
    (s_q.tick && gap_ok_q && !s_q.ctl[`PMR_CTL_FAST_BIT])
    |-> (gap_q == pmr_cnt_t'(P_SLOW_CYC - 1)))
    else $error("slow expiry period wrong");

  a_tick_one_cycle: assert property (
    s_q.tick |=> !s_q.tick)
    else $error("expiry tick longer than one cycle");

  a_reserved_store: assert property (
    (s_q.dev_sts[7] == 1'b0 && s_q.dev_en[7] == 1'b0 && s_q.ctl[7:3] == 5'h00
      && (s_q.aux_sts & ~`PMR_AUX_MASK) == 8'h00 && (s_q.aux_en & ~`PMR_AUX_MASK) == 8'h00))
    else $error("reserved bit held a one");

  a_test_reads_zero: assert property (
    (setup && aligned && (idx == `PMR_IDX_TEST_LO || idx == `PMR_IDX_TEST_HI))
    |=> (o_prdata == 32'h00000000 && !s_q.slverr))
    else $error("test index read non-zero");

  a_reset_status: assert property (
    $past(i_rst) |-> (s_q.dev_sts == 8'h00 && s_q.aux_sts == 8'h00 && !o_smi_oe && !o_sci_oe))
    else $error("status or pin enable not zero after reset");

endmodule

`default_nettype wire

// [sim/pmr_host_pm_model.sv]
// host chipset power-management inputs seen as two open-drain wires
// assumes the router's _n/_oe pairs drive the wires, board pull-ups hold them high
`timescale 1ns/10ps
`default_nettype none

module pmr_host_pm_model (
  // router pin drivers
  input  wire logic i_smi_n,
  input  wire logic i_smi_oe,
  input  wire logic i_sci_n,
  input  wire logic i_sci_oe,
  // resolved wire levels
  output logic      o_smi_line,
  output logic      o_sci_line
);
  // released wire floats to the pull-up level
  assign o_smi_line = (i_smi_oe && !i_smi_n) ? 1'b0 : 1'b1;
  assign o_sci_line = (i_sci_oe && !i_sci_n) ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// [sim/pm_event_smi_sci_router_tb.sv]
// self-checking bench of the power-management event router
// assumes core/ on the include path, host model in sim/, short expiry parameters
`include "pmr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module pm_event_smi_sci_router_tb;
  localparam logic [11:0] A_DST = {`PMR_IDX_DEV_STS, 2'b00};
  localparam logic [11:0] A_AST = {`PMR_IDX_AUX_STS, 2'b00};
  localparam logic [11:0] A_DEN = {`PMR_IDX_DEV_EN, 2'b00};
  localparam logic [11:0] A_AEN = {`PMR_IDX_AUX_EN, 2'b00};
  localparam logic [11:0] A_CTL = {`PMR_IDX_OUT_CTL, 2'b00};
  localparam logic [11:0] A_EVS = {`PMR_IDX_EVT_STS, 2'b00};
  localparam logic [11:0] A_EVM = {`PMR_IDX_EVT_MASK, 2'b00};
  localparam logic [11:0] RA [7] = '{A_DST, A_AST, A_DEN, A_AEN, A_CTL, 12'h3f8, 12'h3fc};
  localparam logic [7:0]  RX [7] = '{8'h00, 8'h00, `PMR_DEV_MASK, `PMR_AUX_MASK,
                                     `PMR_CTL_MASK, 8'h00, 8'h00};
  localparam logic [7:0]  CT [4] = '{8'h00, 8'h01, 8'h05, 8'h04};
  localparam logic [1:0]  PX [4] = '{2'b11, 2'b01, 2'b10, 2'b11};

  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        smi_n, smi_oe, sci_n, sci_oe, fast_sel, tick, irq, smi_line, sci_line;
  logic [11:0] paddr;
  logic [3:0]  strb;
  logic [31:0] pwdata, prdata, d;
  logic [10:0] src;
  logic [64:0] note;
  logic [64:0] notes [$];
  int          errors, comparisons, seed, k, g;

  pmr_router #(.P_SLOW_CYC(40), .P_FAST_CYC(8)) u_pmr_router (
    .i_mclk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_serial_c_irq(src[6]),
    .i_pointer_irq(src[5]), .i_keyboard_ctl_irq(src[4]), .i_printer_irq(src[3]),
    .i_floppy_irq(src[2]), .i_serial_a_irq(src[1]), .i_serial_b_irq(src[0]),
    .i_watchdog_irq(src[7]), .i_pin_group_20_25_irq(src[8]),
    .i_pin11_steer_irq(src[9]), .i_pin10_steer_irq(src[10]), .o_smi_n(smi_n),
    .o_smi_oe(smi_oe), .o_sci_n(sci_n), .o_sci_oe(sci_oe),
    .o_fast_expiry_select(fast_sel), .o_expiry_tick(tick), .o_irq(irq));

  pmr_host_pm_model u_pmr_host_pm_model (
    .i_smi_n(smi_n), .i_smi_oe(smi_oe), .i_sci_n(sci_n), .i_sci_oe(sci_oe),
    .o_smi_line(smi_line), .o_sci_line(sci_line));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // note the expected word, then read; er is the expected error flag
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    notes.push_back({er, m, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic pulse(input int n);
    src[n] <= 1'b1;
    @(posedge clk);
    src[n] <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pins(input logic [1:0] e);
    repeat (3) @(posedge clk);
    check({30'h0, smi_line, sci_line}, {30'h0, e});
  endtask

  task automatic tick_gap;
    k = 0;
    while (tick !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (tick !== 1'b1 && g < 200);
  endtask

  function automatic logic [31:0] bitm(input int n);
    case (n)
      7:       bitm = 32'h1 << `PMR_AUX_WATCHDOG;
      8:       bitm = 32'h1 << `PMR_AUX_PIN_GROUP;
      9:       bitm = 32'h1 << `PMR_AUX_PIN11;
      10:      bitm = 32'h1 << `PMR_AUX_PIN10;
      default: bitm = 32'h1 << n;
    endcase
  endfunction

  // read results are compared against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (notes.size() == 0) begin
        errors++;
      end else begin
        note = notes.pop_front();
        check(prdata & note[63:32], note[31:0]);
        check({31'h0, pslverr}, {31'h0, note[64]});
      end
    end
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, src} = '0;
    strb = 4'hf;
    {errors, comparisons} = '0;
    seed = 127;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (RA[j]) rd(RA[j], 32'h0, 32'hffffffff, 1'b0);
    pins(2'b11);
    foreach (RA[j]) apb(1'b1, RA[j], 32'hffffffff);
    foreach (RA[j]) rd(RA[j], {24'h0, RX[j]}, 32'hffffffff, 1'b0);
    d = $random(seed);
    apb(1'b1, A_DEN, d);
    rd(A_DEN, d & 32'h7f, 32'hffffffff, 1'b0);
    apb(1'b1, A_AEN, d);
    rd(A_AEN, d & 32'h17, 32'hffffffff, 1'b0);
    rd(12'h000, 32'h0, 32'hffffffff, 1'b1);
    rd(12'h3cd, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, A_CTL, 32'h0);
    for (int i = 0; i < 11; i++) begin
      pulse(i);
      rd(i < 7 ? A_DST : A_AST, bitm(i), 32'hffffffff, 1'b0);
      apb(1'b1, i < 7 ? A_DST : A_AST, ~bitm(i));
      rd(i < 7 ? A_DST : A_AST, bitm(i), 32'hffffffff, 1'b0);
      apb(1'b1, i < 7 ? A_DST : A_AST, bitm(i));
      rd(i < 7 ? A_DST : A_AST, 32'h0, 32'hffffffff, 1'b0);
    end
    apb(1'b1, A_DEN, 32'h7f);
    apb(1'b1, A_AEN, 32'h17);
    k = {$random(seed)} % 11;
    pulse(k);
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, A_CTL, {24'h0, CT[j]});
      pins(PX[j]);
    end
    apb(1'b1, A_CTL, 32'h1);
    apb(1'b1, A_DST, 32'h7f);
    apb(1'b1, A_AST, 32'h17);
    pins(2'b11);
    apb(1'b1, A_DEN, 32'h0);
    apb(1'b1, A_AEN, 32'h2);
    pulse(8);
    pins(2'b11);
    pulse(9);
    pins(2'b01);
    apb(1'b1, A_AST, 32'h17);
    apb(1'b1, A_DEN, 32'h1);
    rd(A_EVS, 32'h0, 32'h0, 1'b0);
    apb(1'b1, A_EVM, 32'h1);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    pulse(0);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    rd(A_EVS, 32'h1, 32'h1, 1'b0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    strb <= 4'he;
    apb(1'b1, A_DEN, 32'h7e);
    strb <= 4'hf;
    rd(A_DEN, 32'h1, 32'hffffffff, 1'b0);
    tick_gap();
    check(g, 32'd40);
    apb(1'b1, A_CTL, 32'h2);
    check({31'h0, fast_sel}, 32'h1);
    tick_gap();
    check(g, 32'd8);
    report_and_stop();
  end

  // the sequence needs about 500 cycles; allow thirty times that
  initial begin
    repeat (15000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule

`default_nettype wire
